// ===== logic/pcacc_top.sv
`timescale 1ns/100ps
// Overview of operation
// - idle bit 0 stops counter during processor idle; 1 keeps counting
// - tick source: osc/12, osc/2, timer0 overflow, external count pin
// - overflow irq enable gates the overflow request
// - overflow flag set by hardware on wrap, cleared only by software
// - run bit starts counter; clear holds it
// - four module flags set on match or capture, cleared by software
// - match when counter equals module compare register
// - enabled pin edge copies counter into compare register and sets flag
// - module irq enable forwards module flag as interrupt
// - toggle bit inverts module pin on each match
// - match-flag bit lets a match set the module flag
// - rising and falling capture enables; both means either edge
// - comparator enable turns matching on
// - pwm bit drives module pin with pwm output
// - counter and compare registers accessed as low and high bytes
// - four modules, each with its own mode register
// - pwm low while counter low byte below 9-bit duty; reload on low byte wrap
module pcacc_top
  import pcacc_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // register port
  input  wire pcacc_req_s            req,
  output logic [7:0]                 rdata,
  // system
  input  wire logic                  cpu_idle,
  input  wire logic                  timer0_ovf,
  output logic                       irq,
  // pins
  input  wire logic                  external_count_input,
  input  wire logic [PCACC_NMOD-1:0] module_edge_io_pin_in,
  output logic [PCACC_NMOD-1:0]      module_edge_io_pin_out,
  output logic [PCACC_NMOD-1:0]      module_edge_io_pin_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]            mode_cfg_r;
  logic                  overflow_flag_r;
  logic                  counter_run_r;
  logic [3:0]            ev_flag_r;
  logic [3:0]            irq_mask_r;
  logic                  ovf_mask_r;
  logic [15:0]           cnt_r;
  logic [15:0]           cmp_r  [PCACC_NMOD];
  logic [7:0]            mmode_r[PCACC_NMOD];
  logic [1:0]            ext_r  [PCACC_NMOD];
  logic [3:0]            div_r;
  logic                  div2_r;
  logic [1:0]            eci_sync_r;
  logic                  eci_prev_r;
  logic [PCACC_NMOD-1:0] pin_s1_r;
  logic [PCACC_NMOD-1:0] pin_s2_r;
  logic [PCACC_NMOD-1:0] pin_prev_r;
  logic [PCACC_NMOD-1:0] hso_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] base, input int i);
    hit = (a == (base + 5'(i)));
  endfunction

  wire wr_mode = req.wr && (req.addr == PCACC_A_MODE_CFG);
  wire wr_run  = req.wr && (req.addr == PCACC_A_RUN_FLAGS);
  wire wr_clo  = req.wr && (req.addr == PCACC_A_CNT_LO);
  wire wr_chi  = req.wr && (req.addr == PCACC_A_CNT_HI);
  wire wr_mask = req.wr && (req.addr == PCACC_A_IRQ_MASK);

  // ----------------------------------------------------------------
  // tick source
  // ----------------------------------------------------------------
  wire [1:0] src_sel = {mode_cfg_r[PCACC_B_SRC_HI], mode_cfg_r[PCACC_B_SRC_LO]};
  wire tick_d12 = (div_r == PCACC_DIV12_MAX);
  wire eci_rise = eci_sync_r[1] & ~eci_prev_r;
  wire tick_src = (src_sel == PCACC_SRC_DIV12) ? tick_d12 :
                  (src_sel == PCACC_SRC_DIV2)  ? div2_r :
                  (src_sel == PCACC_SRC_T0OVF) ? timer0_ovf :
                                                 eci_rise;
  wire idle_ok  = mode_cfg_r[PCACC_B_IDLE] | ~cpu_idle;
  wire tick     = tick_src & counter_run_r & idle_ok;
  wire wrap     = tick & (cnt_r == 16'hFFFF);
  wire lo_wrap  = tick & (cnt_r[7:0] == 8'hFF);
  wire step     = tick & ~wr_clo & ~wr_chi;
  wire [15:0] cnt_step = cnt_r + 16'h0001;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_r      <= 4'h0;
      div2_r     <= 1'b0;
      eci_sync_r <= 2'h0;
      eci_prev_r <= 1'b0;
    end else begin
      div_r      <= tick_d12 ? 4'h0 : div_r + 4'h1;
      div2_r     <= ~div2_r;
      eci_sync_r <= {eci_sync_r[0], external_count_input};
      eci_prev_r <= eci_sync_r[1];
    end
  end

  // ----------------------------------------------------------------
  // shared counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
    end else if (wr_clo) begin
      cnt_r[7:0] <= req.wdata;
    end else if (wr_chi) begin
      cnt_r[15:8] <= req.wdata;
    end else if (tick) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_r   <= '0;
      pin_s2_r   <= '0;
      pin_prev_r <= '0;
    end else begin
      pin_s1_r   <= module_edge_io_pin_in;
      pin_s2_r   <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // modules
  // ----------------------------------------------------------------
  logic [3:0] ev_set;
  logic [3:0] match;
  logic [3:0] pwm_lvl;

  genvar gi;
  generate
    for (gi = 0; gi < PCACC_NMOD; gi++) begin : g_mod
      wire [7:0] md   = mmode_r[gi];
      wire rise = pin_s2_r[gi] & ~pin_prev_r[gi];
      wire fall = ~pin_s2_r[gi] & pin_prev_r[gi];
      wire cap  = (md[PCACC_B_RISE] & rise) | (md[PCACC_B_FALL] & fall);
      wire eq   = md[PCACC_B_CMP_EN] & step & (cnt_step == cmp_r[gi]);
      wire w_lo = req.wr && hit(req.addr, PCACC_A_CMP_LO0, gi);
      wire w_hi = req.wr && hit(req.addr, PCACC_A_CMP_HI0, gi);
      wire w_md = req.wr && hit(req.addr, PCACC_A_MOD_MODE0, gi);
      wire w_ex = req.wr && hit(req.addr, PCACC_A_DUTY_EXT0, gi);
      assign match[gi]   = eq;
      assign ev_set[gi]  = cap | (eq & md[PCACC_B_MATF]);
      assign pwm_lvl[gi] = {1'b0, cnt_r[7:0]} >= {ext_r[gi][PCACC_B_EXT_A],
                                                  cmp_r[gi][7:0]};

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          cmp_r[gi]   <= 16'h0000;
          mmode_r[gi] <= PCACC_RST_BYTE;
          ext_r[gi]   <= 2'h0;
          hso_r[gi]   <= 1'b1;
        end else begin
          if (cap) begin
            cmp_r[gi] <= cnt_r;
          end else if (w_lo) begin
            cmp_r[gi][7:0] <= req.wdata;
          end else if (w_hi) begin
            cmp_r[gi][15:8] <= req.wdata;
          end else if (lo_wrap && md[PCACC_B_PWM]) begin
            cmp_r[gi][7:0] <= cmp_r[gi][15:8];
          end
          if (w_md) begin
            mmode_r[gi] <= {1'b0, req.wdata[6:0]};
          end
          if (w_ex) begin
            ext_r[gi] <= req.wdata[1:0];
          end else if (lo_wrap && md[PCACC_B_PWM]) begin
            ext_r[gi][PCACC_B_EXT_A] <= ext_r[gi][PCACC_B_EXT_R];
          end
          if (eq && md[PCACC_B_TOG]) begin
            hso_r[gi] <= ~hso_r[gi];
          end
        end
      end

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          module_edge_io_pin_out[gi] <= 1'b1;
          module_edge_io_pin_oe[gi]  <= 1'b0;
        end else begin
          module_edge_io_pin_out[gi] <= md[PCACC_B_PWM] ? pwm_lvl[gi] : hso_r[gi];
          module_edge_io_pin_oe[gi]  <= md[PCACC_B_PWM] | md[PCACC_B_TOG];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // control and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_cfg_r      <= PCACC_RST_BYTE;
      counter_run_r   <= 1'b0;
      overflow_flag_r <= 1'b0;
      ev_flag_r       <= 4'h0;
      irq_mask_r      <= 4'hF;
      ovf_mask_r      <= 1'b1;
    end else begin
      if (wr_mode) begin
        mode_cfg_r <= req.wdata & 8'h87;
      end
      if (wr_run) begin
        counter_run_r <= req.wdata[PCACC_B_RUN];
      end
      if (wrap) begin
        overflow_flag_r <= 1'b1;
      end else if (wr_run && req.wdata[PCACC_B_OVF_F]) begin
        overflow_flag_r <= 1'b0;
      end
      ev_flag_r <= ev_set | (ev_flag_r & ~(wr_run ? req.wdata[3:0] : 4'h0));
      if (wr_mask) begin
        irq_mask_r <= req.wdata[3:0];
        ovf_mask_r <= req.wdata[PCACC_B_OVF_M];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt and read back
  // ----------------------------------------------------------------
  logic [3:0] mod_ie;
  generate
    for (gi = 0; gi < PCACC_NMOD; gi++) begin : g_ie
      assign mod_ie[gi] = mmode_r[gi][PCACC_B_MIE];
    end
  endgenerate

  wire irq_nxt = (overflow_flag_r & mode_cfg_r[PCACC_B_OVF_IE] & ~ovf_mask_r)
               | (|(ev_flag_r & mod_ie & ~irq_mask_r));

  wire [2:0] sub = 3'(req.addr[1:0]);
  logic [7:0] rd_nxt;
  always_comb begin
    rd_nxt = 8'h00;
    if (req.addr == PCACC_A_MODE_CFG)
      rd_nxt = mode_cfg_r;
    else if (req.addr == PCACC_A_RUN_FLAGS)
      rd_nxt = {overflow_flag_r, counter_run_r, 2'b00, ev_flag_r};
    else if (req.addr == PCACC_A_CNT_LO)
      rd_nxt = cnt_r[7:0];
    else if (req.addr == PCACC_A_CNT_HI)
      rd_nxt = cnt_r[15:8];
    else if (req.addr[4:2] == PCACC_A_CMP_LO0[4:2])
      rd_nxt = cmp_r[sub[1:0]][7:0];
    else if (req.addr[4:2] == PCACC_A_CMP_HI0[4:2])
      rd_nxt = cmp_r[sub[1:0]][15:8];
    else if (req.addr[4:2] == PCACC_A_MOD_MODE0[4:2])
      rd_nxt = mmode_r[sub[1:0]];
    else if (req.addr[4:2] == PCACC_A_DUTY_EXT0[4:2])
      rd_nxt = {6'h00, ext_r[sub[1:0]]};
    else if (req.addr == PCACC_A_IRQ_MASK)
      rd_nxt = {3'h0, ovf_mask_r, irq_mask_r};
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
      irq   <= 1'b0;
    end else begin
      rdata <= req.rd ? rd_nxt : 8'h00;
      irq   <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_ovf_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wrap |=> overflow_flag_r)
    else $error("overflow flag not set on wrap");

  chk_run_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!counter_run_r && !wr_clo && !wr_chi) |=> $stable(cnt_r))
    else $error("counter moved while stopped");

  chk_idle_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (cpu_idle && !mode_cfg_r[PCACC_B_IDLE] && !wr_clo && !wr_chi) |=> $stable(cnt_r))
    else $error("counter moved in idle");

  chk_tick_incr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tick && !wr_clo && !wr_chi) |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter did not step");

  chk_div12_gap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tick_d12 |=> !tick_d12 [*8] ##1 !tick_d12 [*3] ##1 tick_d12)
    else $error("divide by 12 broken");

  chk_ev_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ev_set[0] |=> ev_flag_r[0])
    else $error("module flag lost");

  chk_capture_copy: assert property (@(posedge clk_sys) disable iff (!rst_b)
    g_mod[1].cap |=> cmp_r[1] == $past(cnt_r))
    else $error("capture value wrong");

  chk_irq_follows: assert property (@(posedge clk_sys) disable iff (!rst_b)
    irq_nxt |=> irq)
    else $error("interrupt not raised");

  chk_toggle_pin: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (match[2] && mmode_r[2][PCACC_B_TOG]) |=> hso_r[2] != $past(hso_r[2]))
    else $error("toggle missing");

  chk_div2_rate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    div2_r |=> !div2_r)
    else $error("divide by 2 broken");

  chk_ovf_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!mode_cfg_r[PCACC_B_OVF_IE] && !(|(ev_flag_r & mod_ie & ~irq_mask_r))) |=> !irq)
    else $error("overflow irq not blocked");

  chk_ovf_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (overflow_flag_r && !(wr_run && req.wdata[PCACC_B_OVF_F])) |=> overflow_flag_r)
    else $error("overflow flag lost");

  chk_ovf_only_wrap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!overflow_flag_r && !wrap) |=> !overflow_flag_r)
    else $error("overflow flag set without wrap");

  chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ev_flag_r[1] && !(wr_run && req.wdata[1])) |=> ev_flag_r[1])
    else $error("module flag dropped");

  chk_match_noflag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (match[3] && !mmode_r[3][PCACC_B_MATF] && !g_mod[3].cap && !ev_flag_r[3])
    |=> !ev_flag_r[3])
    else $error("match set flag while disabled");

  chk_match_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (match[1] && mmode_r[1][PCACC_B_MATF]) |=> ev_flag_r[1])
    else $error("match did not set flag");

  chk_cmp_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !mmode_r[0][PCACC_B_CMP_EN] |-> !match[0])
    else $error("match with comparator off");

  chk_no_toggle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !mmode_r[1][PCACC_B_TOG] |=> $stable(hso_r[1]))
    else $error("pin toggled while disabled");

  chk_mod_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!overflow_flag_r && !(|(ev_flag_r & mod_ie))) |=> !irq)
    else $error("module irq not blocked");

  chk_pin_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !mmode_r[2][PCACC_B_PWM] |=> module_edge_io_pin_out[2] == $past(hso_r[2]))
    else $error("pwm level on pin while off");

  chk_pwm_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
    mmode_r[0][PCACC_B_PWM] |=> module_edge_io_pin_out[0] == $past(pwm_lvl[0]))
    else $error("pwm level wrong");

  chk_pwm_reload: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (lo_wrap && mmode_r[0][PCACC_B_PWM] && !g_mod[0].cap && !g_mod[0].w_lo
     && !g_mod[0].w_hi) |=> cmp_r[0][7:0] == $past(cmp_r[0][15:8]))
    else $error("pwm duty not reloaded");

  chk_edge_once: assert property (@(posedge clk_sys) disable iff (!rst_b)
    g_mod[2].rise |=> !g_mod[2].rise)
    else $error("edge seen twice");

  chk_byte_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_clo |=> cnt_r[7:0] == $past(req.wdata))
    else $error("counter low byte not written");

  chk_wrap_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wrap && !wr_clo && !wr_chi) |=> cnt_r == 16'h0000)
    else $error("counter did not wrap to zero");

endmodule // pcacc_top

// ===== logic/pcacc_pkg.sv
package pcacc_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] PCACC_A_MODE_CFG  = 5'h00;
  localparam logic [4:0] PCACC_A_RUN_FLAGS = 5'h01;
  localparam logic [4:0] PCACC_A_CNT_LO    = 5'h02;
  localparam logic [4:0] PCACC_A_CNT_HI    = 5'h03;
  localparam logic [4:0] PCACC_A_CMP_LO0   = 5'h04;
  localparam logic [4:0] PCACC_A_CMP_HI0   = 5'h08;
  localparam logic [4:0] PCACC_A_MOD_MODE0 = 5'h0C;
  localparam logic [4:0] PCACC_A_DUTY_EXT0 = 5'h10;
  localparam logic [4:0] PCACC_A_IRQ_MASK  = 5'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PCACC_B_IDLE   = 7;
  localparam int PCACC_B_SRC_HI = 2;
  localparam int PCACC_B_SRC_LO = 1;
  localparam int PCACC_B_OVF_IE = 0;
  localparam int PCACC_B_OVF_F  = 7;
  localparam int PCACC_B_RUN    = 6;
  localparam int PCACC_B_OVF_M  = 4;
  localparam int PCACC_B_CMP_EN = 6;
  localparam int PCACC_B_RISE   = 5;
  localparam int PCACC_B_FALL   = 4;
  localparam int PCACC_B_MATF   = 3;
  localparam int PCACC_B_TOG    = 2;
  localparam int PCACC_B_PWM    = 1;
  localparam int PCACC_B_MIE    = 0;
  localparam int PCACC_B_EXT_A  = 0;
  localparam int PCACC_B_EXT_R  = 1;

  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] PCACC_RST_BYTE  = 8'h00;
  localparam int         PCACC_NMOD      = 4;
  localparam logic [1:0] PCACC_SRC_DIV12 = 2'h0;
  localparam logic [1:0] PCACC_SRC_DIV2  = 2'h1;
  localparam logic [1:0] PCACC_SRC_T0OVF = 2'h2;
  localparam logic [1:0] PCACC_SRC_EXTIN = 2'h3;
  localparam logic [3:0] PCACC_DIV12_MAX = 4'hB;

  // ----------------------------------------------------------------
  // bus carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pcacc_req_s;

endpackage

// ===== verif/pcacc_pin_model.sv
`timescale 1ns/100ps
module pcacc_pin_model
  import pcacc_pkg::*;
(
  // pins from the block
  input  wire logic [PCACC_NMOD-1:0] pin_out,
  input  wire logic [PCACC_NMOD-1:0] pin_oe,
  // levels asked of the far side
  input  wire logic [PCACC_NMOD-1:0] drv,
  input  wire logic                  ext_drv,
  // pins seen by the block
  output logic [PCACC_NMOD-1:0]      pin_in,
  output logic                       ext_in
);
  // ----------------------------------------------------------------
  // wire level: block wins where enabled, far side elsewhere
  // ----------------------------------------------------------------
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
  assign ext_in = ext_drv;
endmodule // pcacc_pin_model

// ===== verif/testbench.sv
`timescale 1ns/100ps
module testbench
  import pcacc_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  pcacc_req_s  req     = '0;
  logic [7:0]  rdata;
  logic        cpu_idle = 1'b0;
  logic        t0       = 1'b0;
  logic        irq;
  logic        ext_drv  = 1'b0;
  logic        ext_in;
  logic [3:0]  drv      = 4'h0;
  logic [3:0]  pin_in;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          seed      = 62;
  int          n;
  logic [7:0]  v;
  logic [15:0] a;
  logic [15:0] r;

  always #12.5 clk_sys = ~clk_sys;

  pcacc_top pcacc_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata),
    .cpu_idle(cpu_idle), .timer0_ovf(t0), .irq(irq), .external_count_input(ext_in),
    .module_edge_io_pin_in(pin_in), .module_edge_io_pin_out(pin_out),
    .module_edge_io_pin_oe(pin_oe));
  pcacc_pin_model pcacc_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .drv(drv),
    .ext_drv(ext_drv), .pin_in(pin_in), .ext_in(ext_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [4:0] ad, logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req <= '0;
  endtask
  task automatic rd(logic [4:0] ad, output logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1 d = rdata;
  endtask
  task automatic wr16(logic [4:0] lo, logic [4:0] hi, logic [15:0] d);
    wr(lo, d[7:0]);
    wr(hi, d[15:8]);
  endtask
  task automatic rd16(logic [4:0] lo, logic [4:0] hi, output logic [15:0] d);
    rd(lo, d[7:0]);
    rd(hi, d[15:8]);
  endtask
  task automatic tick(int cnt);
    repeat (cnt) begin
      @(posedge clk_sys);
      t0 <= 1'b1;
      @(posedge clk_sys);
      t0 <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic pass(int k, logic [7:0] m);
    wr(5'(PCACC_A_MOD_MODE0 + k), 8'h00);
    wr16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, a - 16'h0001);
    wr(5'(PCACC_A_MOD_MODE0 + k), m);
    wr(PCACC_A_RUN_FLAGS, 8'h40);
    tick(1);
    wr(PCACC_A_RUN_FLAGS, 8'h00);
    rd(PCACC_A_RUN_FLAGS, v);
  endtask
  task automatic cap(int k, logic lvl, logic [15:0] cv, logic [15:0] exp, logic [7:0] f);
    wr(PCACC_A_RUN_FLAGS, 8'h0F);
    wr16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, cv);
    @(posedge clk_sys);
    drv[k] <= lvl;
    repeat (8) @(posedge clk_sys);
    rd16(5'(PCACC_A_CMP_LO0 + k), 5'(PCACC_A_CMP_HI0 + k), r);
    chk("capture value", r, exp);
    rd(PCACC_A_RUN_FLAGS, v);
    chk("capture flag", {8'h00, v & 8'h0F}, {8'h00, f});
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 60000);
    error_cnt++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk("oe after reset", {12'h000, pin_oe}, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      rd(i[4:0], v);
      chk("reset value", {8'h00, v}, (i == 20) ? 16'h001F : 16'h0000);
    end
    for (int k = 0; k < 4; k++) begin
      a = 16'($random(seed)) ^ 16'(k);
      wr16(5'(PCACC_A_CMP_LO0 + k), 5'(PCACC_A_CMP_HI0 + k), a);
      rd16(5'(PCACC_A_CMP_LO0 + k), 5'(PCACC_A_CMP_HI0 + k), r);
      chk("compare bytes", r, a);
    end
    a = 16'($random(seed));
    wr16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, a);
    rd16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, r);
    chk("counter held", r, a);
    $display("test registers done");
    wr(PCACC_A_MODE_CFG, 8'h04);
    wr(PCACC_A_RUN_FLAGS, 8'h40);
    n = 1 + ($random(seed) & 7);
    tick(n);
    rd16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, r);
    chk("timer0 ticks", r, a + 16'(n));
    cpu_idle <= 1'b1;
    tick(3);
    rd16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, r);
    chk("idle stop", r, a + 16'(n));
    wr(PCACC_A_MODE_CFG, 8'h84);
    tick(2);
    rd16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, r);
    chk("idle count", r, a + 16'(n + 2));
    @(posedge clk_sys);
    cpu_idle <= 1'b0;
    wr(PCACC_A_MODE_CFG, 8'h06);
    @(posedge clk_sys);
    repeat (n) begin
      ext_drv <= 1'b1;
      repeat (5) @(posedge clk_sys);
      ext_drv <= 1'b0;
      repeat (5) @(posedge clk_sys);
    end
    rd16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, r);
    chk("external ticks", r, a + 16'(2 * n + 2));
    for (int s = 0; s < 2; s++) begin
      wr(PCACC_A_RUN_FLAGS, 8'h00);
      wr(PCACC_A_MODE_CFG, s ? 8'h00 : 8'h02);
      wr16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, 16'h0000);
      wr(PCACC_A_RUN_FLAGS, 8'h40);
      repeat (s ? 240 : 48) @(posedge clk_sys);
      wr(PCACC_A_RUN_FLAGS, 8'h00);
      rd16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, r);
      n = s ? 20 : 25;
      chk("divided rate", 16'(r + 1 >= n && r <= n + 1), 16'h0001);
    end
    $display("test tick sources done");
    wr(PCACC_A_IRQ_MASK, 8'h0F);
    for (int e = 1; e >= 0; e--) begin
      wr(PCACC_A_MODE_CFG, 8'h04 | 8'(e));
      wr16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, 16'hFFFF);
      wr(PCACC_A_RUN_FLAGS, 8'h40);
      tick(1);
      rd16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, r);
      chk("wrap to zero", r, 16'h0000);
      chk("overflow irq", {15'h0000, irq}, 16'(e));
      wr(PCACC_A_RUN_FLAGS, 8'h40);
      rd(PCACC_A_RUN_FLAGS, v);
      chk("overflow sticky", {8'h00, v}, 16'h00C0);
      wr(PCACC_A_RUN_FLAGS, 8'hC0);
      rd(PCACC_A_RUN_FLAGS, v);
      chk("overflow clear", {7'h00, irq, v}, 16'h0040);
    end
    $display("test overflow done");
    wr(PCACC_A_RUN_FLAGS, 8'h00);
    wr(PCACC_A_IRQ_MASK, 8'h10);
    for (int k = 0; k < 4; k++) begin
      a = 16'($random(seed)) | 16'h0100;
      wr16(5'(PCACC_A_CMP_LO0 + k), 5'(PCACC_A_CMP_HI0 + k), a);
      pass(k, 8'h0D);
      chk("comparator off", {11'h000, pin_out[k], v & 8'h0F}, 16'h0100);
      pass(k, 8'h45);
      chk("toggle no flag", {11'h000, pin_out[k], v & 8'h0F}, 16'h0000);
      pass(k, 8'h4D);
      chk("match flag", {11'h000, pin_out[k], v & 8'h0F}, 16'h0100 | 16'(1 << k));
      chk("module irq", {12'h000, irq, pin_oe[k], 2'h0}, 16'h000C);
      wr(PCACC_A_IRQ_MASK, 8'h10 | 8'(1 << k));
      #50 chk("masked irq", {15'h0000, irq}, 16'h0000);
      wr(PCACC_A_IRQ_MASK, 8'h10);
      wr16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, a + 16'h0003);
      wr(PCACC_A_RUN_FLAGS, 8'h0F);
      #50 chk("flag cleared", {15'h0000, irq}, 16'h0000);
      wr(5'(PCACC_A_MOD_MODE0 + k), 8'h20);
      a = 16'($random(seed));
      cap(k, 1'b1, a, a, 8'(1 << k));
      cap(k, 1'b0, a + 16'h0001, a, 8'h00);
      wr(5'(PCACC_A_MOD_MODE0 + k), 8'h30);
      cap(k, 1'b1, a + 16'h0002, a + 16'h0002, 8'(1 << k));
      cap(k, 1'b0, a + 16'h0003, a + 16'h0003, 8'(1 << k));
      wr(5'(PCACC_A_MOD_MODE0 + k), 8'h00);
      wr(PCACC_A_RUN_FLAGS, 8'h0F);
    end
    $display("test modules done");
    wr(PCACC_A_CMP_LO0, 8'h80);
    wr(PCACC_A_MOD_MODE0, 8'h42);
    for (int p = 0; p < 3; p++) begin
      if (p == 2) begin
        wr(PCACC_A_DUTY_EXT0, 8'h01);
      end
      wr16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, (p == 0) ? 16'h007F : 16'h0080);
      repeat (4) @(posedge clk_sys);
      #1 chk("pwm level", {14'h0000, pin_oe[0], pin_out[0]}, (p == 1) ? 16'h0003 : 16'h0002);
    end
    wr(PCACC_A_CMP_HI0, 8'h20);
    wr16(PCACC_A_CNT_LO, PCACC_A_CNT_HI, 16'h00FF);
    wr(PCACC_A_RUN_FLAGS, 8'h40);
    tick(1);
    wr(PCACC_A_RUN_FLAGS, 8'h00);
    rd(PCACC_A_CMP_LO0, v);
    rd(PCACC_A_DUTY_EXT0, r[7:0]);
    chk("pwm reload", {v, r[7:0]}, 16'h2000);
    wr(PCACC_A_MOD_MODE0, 8'h00);
    #50 chk("pwm off", {15'h0000, pin_oe[0]}, 16'h0000);
    $display("test pwm done");
    wrap_up();
  end
endmodule // testbench
